// file: src/sptx_pkg.sv
// Shared constants and types for the S/PDIF transmit encoder.
// Assumes one 50 MHz clock and a plain one-cycle register port.
package sptx_pkg;
  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SLOTEN = 8'h04;
  localparam logic [7:0] OFS_SER    = 8'h08;
  localparam logic [7:0] OFS_CLK    = 8'h0C;
  localparam logic [7:0] OFS_VALID  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_FILE   = 8'h40; // 24 words follow
  // Control fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_LOOP_BIT  = 1;
  // Clock control fields
  localparam int CLK_DIV_MSB    = 7;
  localparam int CLK_HF_EXT_BIT = 8;
  localparam int CLK_BC_EXT_BIT = 9;
  localparam int CLK_MCO_BIT    = 10;
  // Status fields
  localparam int ST_SLOT_MSB    = 8;
  localparam int ST_CLKFAIL_BIT = 16;
  localparam int ST_UNDER_BIT   = 17;
  // Reset values and the all-slots enable mask
  localparam logic [31:0] SLOTEN_RST = 32'h0000_0000;
  localparam logic [31:0] ALL_SLOTS  = 32'hFFFF_FFFF;
  localparam logic [7:0]  DIV_RST    = 8'h00;
  // Block geometry
  localparam int FILE_WORDS = 6;
  localparam int NUM_FILES  = 4;
  localparam logic [8:0] LAST_SLOT = 9'h17F; // 384 subframes
  localparam logic [5:0] LAST_HALF = 6'h3F;  // 64 half cells
  // File bases: left status, right status, left user, right user
  localparam logic [4:0] CSL_BASE = 5'h00;
  localparam logic [4:0] CSR_BASE = 5'h06;
  localparam logic [4:0] UDL_BASE = 5'h0C;
  localparam logic [4:0] UDR_BASE = 5'h12;
  // Subframe bit positions
  localparam int SF_AUD_LSB = 4;
  localparam int SF_V_BIT   = 28;
  localparam int SF_U_BIT   = 29;
  localparam int SF_C_BIT   = 30;
  // Preamble half-cell patterns, sent msb first from a low line
  localparam logic [7:0] PAT_B = 8'hE8;
  localparam logic [7:0] PAT_M = 8'hE2;
  localparam logic [7:0] PAT_W = 8'hE4;

  typedef enum logic [1:0] {PRE_B, PRE_M, PRE_W} sptx_pre_e;
  typedef enum {ST_IDLE, ST_RUN} sptx_state_e;

  // Command to every lane at a subframe start
  typedef struct packed {
    logic        load;
    sptx_pre_e   pre;
    logic [30:0] word; // bits 30..4 used, parity added by lane
  } sptx_cmd_s;
endpackage : sptx_pkg

// file: src/sptx_lane.sv
// One serial data lane: biphase mark encoder with preamble insertion.
// Assumes a shared half-cell tick and half-cell index from the sequencer.
`timescale 1ns/1ps
module sptx_lane
  import sptx_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tick,
  input  wire logic [5:0] i_half,
  input  wire sptx_cmd_s  i_cmd,
  output logic            o_level
);
  logic [31:0] word_reg;
  logic [7:0]  pat_reg;
  logic        base_reg;
  logic [31:0] word_next;
  logic [7:0]  pat_next;
  logic        bit_val;

  // Parity makes bits 4..31 carry an even count of ones
  always_comb begin
    word_next = {^i_cmd.word[30:SF_AUD_LSB], i_cmd.word};
    unique case (i_cmd.pre)
      PRE_B:   pat_next = PAT_B;
      PRE_M:   pat_next = PAT_M;
      default: pat_next = PAT_W;
    endcase
    bit_val = word_reg[i_half[5:1]];
  end

  // Latch the subframe and the line level it starts from
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      word_reg <= '0;
      pat_reg  <= '0;
      base_reg <= 1'b0;
    end else if (i_tick && i_cmd.load) begin
      word_reg <= word_next;
      pat_reg  <= pat_next;
      base_reg <= o_level;
    end
  end

  // Preamble violates biphase; then toggle per cell, mid-cell on one
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
    end else if (i_tick) begin
      if (i_cmd.load) begin
        o_level <= pat_next[7] ^ o_level;
      end else if (i_half < 6'h08) begin
        o_level <= pat_reg[3'(7 - i_half)] ^ base_reg;
      end else if (!i_half[0] || bit_val) begin
        o_level <= ~o_level;
      end
    end
  end
endmodule : sptx_lane

// file: src/sptx_encoder.sv
// S/PDIF transmit encoder: register file, subframe sequencer, lanes.
// Assumes synchronous inputs and a one-cycle-read register port.
//
// What this block does
// - Only serializers set as transmitters are driven in this mode.
// - Two-slot transmitter sending biphase mark with inserted bit fields.
// - Separate even/odd validity bits and 384 bits each of status, user.
// - Software enables all slots; slot counter only counts subframes.
// - External master clock optional; monitored for stability when used.
// - All transmitting pins in lock-step, sharing status, user, validity.
// - Any mix of internal/external master and bit clock works.
// - Enable bit set to one selects this transmit mode.
// - Loopback is unavailable while this mode is active.
// - Divider sets bit rate unless the bit clock is external; then each bit clock pin rise is one tick.
// - Data pins output; master clock pin input, or driven if internal and the CLK_MCO_BIT is set.
// - Status and user files single-buffered; live word write is racy.
// - Four six-word files: left/right status, left/right user data.
// - Block of 192 frames, each left then right subframe.
// - Frame f uses word f/32, bit f mod 32 of its file.
`timescale 1ns/1ps
module sptx_encoder
  import sptx_pkg::*;
#(
  parameter int LANES         = 4,
  parameter int CLK_CHECK_MAX = 256 // cycles without a master clock edge
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [31:0] i_audio [LANES],
  input  wire logic        i_audio_valid,
  output logic             o_audio_ready,
  input  wire logic        i_tx_master_clock,
  output logic             o_tx_master_clock,
  output logic             o_tx_master_clock_oe,
  input  wire logic        i_tx_bit_clock,
  output logic             o_tx_bit_clock,
  output logic [LANES-1:0] o_serial_data,
  output logic [LANES-1:0] o_serial_data_oe,
  output logic             o_loopback_en
);
  logic              en_reg;
  logic              loop_reg;
  logic [31:0]       sloten_reg;
  logic [LANES-1:0]  role_reg;
  logic [10:0]       clk_reg;
  logic [1:0]        valid_reg;
  logic              clkfail_reg;
  logic              under_reg;
  logic [31:0]       file_reg [FILE_WORDS*NUM_FILES];
  sptx_state_e       state_reg;
  logic [8:0]        slot_reg;
  logic [5:0]        half_reg;
  logic [7:0]        div_reg;
  logic [31:0]       buf_reg [LANES];
  logic              full_reg;
  logic              mclk_reg;
  logic              mclk_prev_reg;
  logic              bclk_prev_reg;
  logic              bclk_out_reg;
  logic [15:0]       chk_reg;
  logic [4:0]        fidx;
  logic              file_hit;
  logic              src_edge;
  logic              tick;
  logic              load;
  logic [8:0]        slot_next;
  logic [7:0]        frame;
  logic [2:0]        wsel;
  logic [4:0]        bsel;
  logic              sub;
  logic              take;
  logic              w1c_under;
  logic              w1c_fail;
  sptx_cmd_s         cmd [LANES];
  logic [LANES-1:0]  lane_lvl;

  assign fidx     = 5'(i_addr[6:2] - OFS_FILE[6:2]);
  assign file_hit = (i_addr >= OFS_FILE) && (fidx < 5'(FILE_WORDS*4));

  // Control registers; loopback bit is kept but never acts in this mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_reg     <= 1'b0;
      loop_reg   <= 1'b0;
      sloten_reg <= SLOTEN_RST;
      role_reg   <= '0;
      clk_reg    <= {3'h0, DIV_RST};
      valid_reg  <= 2'h0;
    end else if (i_wr) begin
      unique case (i_addr)
        OFS_CTRL: begin
          en_reg   <= i_wdata[CTRL_EN_BIT];
          loop_reg <= i_wdata[CTRL_LOOP_BIT];
        end
        OFS_SLOTEN: sloten_reg <= i_wdata;
        OFS_SER:    role_reg   <= i_wdata[LANES-1:0];
        OFS_CLK:    clk_reg    <= i_wdata[10:0];
        OFS_VALID:  valid_reg  <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Status and user files; single-buffered so the encoder reads live
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < FILE_WORDS*NUM_FILES; k++) begin
        file_reg[k] <= '0;
      end
    end else if (i_wr && file_hit) begin
      file_reg[fidx] <= i_wdata;
    end
  end

  // Read port: data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (file_hit) begin
        o_rdata <= file_reg[fidx];
      end else begin
        unique case (i_addr)
          OFS_CTRL:   o_rdata <= 32'({loop_reg, en_reg});
          OFS_SLOTEN: o_rdata <= sloten_reg;
          OFS_SER:    o_rdata <= 32'(role_reg);
          OFS_CLK:    o_rdata <= 32'(clk_reg);
          OFS_VALID:  o_rdata <= 32'(valid_reg);
          OFS_STATUS: o_rdata <= {14'h0, under_reg, clkfail_reg,
                                  7'h0, slot_reg};
          default:    o_rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      o_rdata <= '0;
    end
  end

  // Loopback is forced off whenever the encoder is enabled
  assign o_loopback_en = loop_reg && !en_reg;

  // Internal aux clock, driven out on the master clock pin on request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mclk_reg <= 1'b0;
    end else begin
      mclk_reg <= ~mclk_reg;
    end
  end
  assign o_tx_master_clock    = mclk_reg;
  assign o_tx_master_clock_oe = !clk_reg[CLK_HF_EXT_BIT] &&
                                clk_reg[CLK_MCO_BIT];

  // Edge history of the pin clocks, already synchronous to i_clk
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mclk_prev_reg <= 1'b0;
      bclk_prev_reg <= 1'b0;
    end else begin
      mclk_prev_reg <= i_tx_master_clock;
      bclk_prev_reg <= i_tx_bit_clock;
    end
  end

  // Source edge is every cycle or each external master clock rise
  assign src_edge = clk_reg[CLK_HF_EXT_BIT] ?
                    (i_tx_master_clock && !mclk_prev_reg) : 1'b1;

  // Clock check: flag a stalled external reference; set beats clear
  assign w1c_fail  = i_wr && (i_addr == OFS_STATUS) &&
                     i_wdata[ST_CLKFAIL_BIT];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      chk_reg     <= '0;
      clkfail_reg <= 1'b0;
    end else if (!clk_reg[CLK_HF_EXT_BIT] || src_edge) begin
      chk_reg     <= '0;
      clkfail_reg <= clkfail_reg && !w1c_fail;
    end else if (chk_reg >= 16'(CLK_CHECK_MAX)) begin
      clkfail_reg <= 1'b1;
    end else begin
      chk_reg     <= chk_reg + 16'h0001;
      clkfail_reg <= clkfail_reg && !w1c_fail;
    end
  end

  // Divider: one half-cell tick every div+1 source edges
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !en_reg) begin
      div_reg <= '0;
    end else if (src_edge) begin
      div_reg <= (div_reg >= clk_reg[CLK_DIV_MSB:0]) ? 8'h00 :
                 div_reg + 8'h01;
    end
  end
  assign tick = en_reg && (clk_reg[CLK_BC_EXT_BIT] ?
                (i_tx_bit_clock && !bclk_prev_reg) :
                (src_edge && div_reg >= clk_reg[CLK_DIV_MSB:0]));

  // Bit clock pin shows the half-cell rate; the protocol ignores it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bclk_out_reg <= 1'b0;
    end else if (tick) begin
      bclk_out_reg <= ~bclk_out_reg;
    end
  end
  assign o_tx_bit_clock = bclk_out_reg;

  // Sequencer: 64 half cells per subframe, 384 subframes per block
  assign load      = tick && (half_reg == LAST_HALF);
  assign slot_next = (slot_reg == LAST_SLOT) ? 9'h000 :
                     slot_reg + 9'h001;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      half_reg  <= LAST_HALF;
      slot_reg  <= LAST_SLOT;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          half_reg <= LAST_HALF;
          slot_reg <= LAST_SLOT;
          if (en_reg) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en_reg) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            half_reg <= half_reg + 6'h01;
            if (load) begin
              slot_reg <= slot_next;
            end
          end
        end
      endcase
    end
  end

  // Subframe fields: frame f picks word f/32, bit f mod 32
  assign frame = slot_next[8:1];
  assign sub   = slot_next[0];
  assign wsel  = frame[7:5];
  assign bsel  = frame[4:0];

  // Sample holding word per lane; lanes drain in lock-step
  assign o_audio_ready = en_reg && !full_reg;
  assign take          = i_audio_valid && o_audio_ready;
  assign w1c_under     = i_wr && (i_addr == OFS_STATUS) &&
                         i_wdata[ST_UNDER_BIT];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      full_reg  <= 1'b0;
      under_reg <= 1'b0;
      for (int k = 0; k < LANES; k++) begin
        buf_reg[k] <= '0;
      end
    end else begin
      if (take) begin
        full_reg <= 1'b1;
        for (int k = 0; k < LANES; k++) begin
          buf_reg[k] <= i_audio[k];
        end
      end else if (load && state_reg == ST_RUN) begin
        full_reg <= 1'b0;
      end
      // Underrun sends silence; a new underrun wins over its clear
      if (load && state_reg == ST_RUN && !full_reg) begin
        under_reg <= 1'b1;
      end else if (w1c_under) begin
        under_reg <= 1'b0;
      end
    end
  end

  // Lane commands: own audio, shared status, user and validity
  always_comb begin
    for (int k = 0; k < LANES; k++) begin
      cmd[k].load = load && (state_reg == ST_RUN);
      cmd[k].pre  = sub ? PRE_W :
                    (frame == 8'h00) ? PRE_B : PRE_M;
      cmd[k].word = '0;
      cmd[k].word[27:SF_AUD_LSB] =
        full_reg ? buf_reg[k][23:0] : 24'h000000;
      cmd[k].word[SF_V_BIT] = valid_reg[sub];
      cmd[k].word[SF_U_BIT] =
        file_reg[(sub ? UDR_BASE : UDL_BASE) + 5'(wsel)][bsel];
      cmd[k].word[SF_C_BIT] =
        file_reg[(sub ? CSR_BASE : CSL_BASE) + 5'(wsel)][bsel];
    end
  end

  // One encoder per serial data pin, all on the same tick
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    sptx_lane u_lane (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_tick  (tick && state_reg == ST_RUN),
      .i_half  (half_reg + 6'h01),
      .i_cmd   (cmd[g]),
      .o_level (lane_lvl[g])
    );
  end

  // Only transmitter lanes drive; receivers stay untouched
  assign o_serial_data    = lane_lvl & role_reg;
  assign o_serial_data_oe = role_reg & {LANES{en_reg}};

  // Checks
  slot_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    load && state_reg == ST_RUN && en_reg && slot_reg == LAST_SLOT
    |=> slot_reg == 9'h000)
    else $error("slot counter did not wrap after 384");
  half_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_reg == ST_RUN && en_reg && tick && half_reg != LAST_HALF
    |=> half_reg == $past(half_reg) + 6'h01)
    else $error("half cell index did not advance");
  block_pre_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd[0].load && slot_reg == LAST_SLOT |-> cmd[0].pre == PRE_B)
    else $error("block start without B preamble");
  right_pre_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd[0].load && !slot_reg[0] |-> cmd[0].pre == PRE_W)
    else $error("right subframe without W preamble");
  rx_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_serial_data_oe & ~role_reg) == '0)
    else $error("non transmitter lane driven");
  no_loop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    en_reg |-> !o_loopback_en)
    else $error("loopback active in transmit mode");
  clk_fail_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clk_reg[CLK_HF_EXT_BIT] && !src_edge &&
    chk_reg >= 16'(CLK_CHECK_MAX) |=> clkfail_reg)
    else $error("stalled master clock not flagged");
  lane_sync_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd[0].load |-> cmd[LANES-1].word[30:28] == cmd[0].word[30:28])
    else $error("lanes differ in shared bits");
  idle_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !en_reg ##1 !en_reg |=> half_reg == LAST_HALF && slot_reg == LAST_SLOT)
    else $error("sequencer not parked while disabled");
endmodule : sptx_encoder

// file: dv/sptx_rx_model.sv
// Behavioural receiver for one lane of the S/PDIF transmit encoder.
// Assumes a fixed half-cell period of HALF clocks and a low line at start.
`timescale 1ns/1ps
module sptx_rx_model #(
  parameter int HALF = 4,
  parameter int NSF  = 68
)(
  input  wire logic   i_clk,
  input  wire logic   i_line,
  output logic [31:0] o_sf  [NSF],
  output logic [7:0]  o_pre [NSF],
  output int          o_count,
  output int          o_errs
);
  // Lock on the first rise, then sample mid half-cell; no clock recovery,
  // so any drift in the encoder tick rate shows up as decode errors
  initial begin : rx
    logic h [64];
    logic last;
    o_count = 0;
    o_errs  = 0;
    last    = 1'b0;
    @(posedge i_clk iff i_line === 1'b1);
    repeat (HALF / 2) @(posedge i_clk);
    for (int n = 0; n < NSF; n++) begin
      for (int k = 0; k < 64; k++) begin
        h[k] = i_line;
        repeat (HALF) @(posedge i_clk);
      end
      // Preamble normalised as if sent from a low line
      for (int j = 0; j < 8; j++) begin
        o_pre[n][7-j] = h[j] ^ last;
      end
      o_sf[n] = '0;
      for (int b = 4; b < 32; b++) begin
        if (h[2*b] === h[2*b-1]) o_errs++; // Cell edge missing
        o_sf[n][b] = h[2*b] ^ h[2*b+1]; // Mid-cell edge is a one
      end
      last    = h[63];
      o_count = n + 1;
    end
  end
endmodule : sptx_rx_model

// file: dv/tb_top.sv
// Self-checking bench for the S/PDIF transmit encoder, three lanes.
// Assumes the register map and timing given in the encoder hand-over.
`timescale 1ns/1ps
module tb_top
  import sptx_pkg::*;
;
  localparam int LN  = 3;
  localparam int NSF = 68;
  localparam int CCM = 8;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sptx_row_s;
  // Words 0 and 1 of left/right status, then left/right user files
  localparam logic [31:0] FW [8] = '{32'hA5C3_0F96, 32'h0000_0001,
    32'h5A3C_F069, 32'h8000_0000, 32'h0F0F_3355, 32'hFFFF_FFFE,
    32'hC3A5_960F, 32'h1234_5678};
  sptx_row_s rows [5] = '{'{OFS_SLOTEN, ALL_SLOTS, ALL_SLOTS},
    '{OFS_VALID, 32'h0000_0001, 32'h0000_0001},
    '{OFS_SER, 32'h0000_0003, 32'h0000_0003},
    '{OFS_CLK, 32'h0000_0003, 32'h0000_0003},
    '{8'h20, 32'h1234_5678, 32'h0000_0000}};
  logic          i_clk, i_rst_n, i_wr, i_rd, i_audio_valid, mclk, bclk;
  logic [7:0]    i_addr;
  logic [31:0]   i_wdata, o_rdata;
  logic [31:0]   aud [LN];
  logic          rdy, mco, mco_oe, bco, loop_en;
  logic [LN-1:0] sd, sd_oe;
  logic [31:0]   sf0 [NSF], sf1 [NSF];
  logic [7:0]    pre0 [NSF], pre1 [NSF];
  int            failures, compares, take_n, cnt0, cnt1, err0, err1;

  sptx_encoder #(.LANES(LN), .CLK_CHECK_MAX(CCM)) u_sptx_encoder (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_audio(aud),
    .i_audio_valid(i_audio_valid), .o_audio_ready(rdy),
    .i_tx_master_clock(mclk), .o_tx_master_clock(mco),
    .o_tx_master_clock_oe(mco_oe), .i_tx_bit_clock(bclk),
    .o_tx_bit_clock(bco), .o_serial_data(sd), .o_serial_data_oe(sd_oe),
    .o_loopback_en(loop_en));
  sptx_rx_model #(.HALF(4), .NSF(NSF)) u_rx0 (.i_clk(i_clk),
    .i_line(sd[0]), .o_sf(sf0), .o_pre(pre0), .o_count(cnt0), .o_errs(err0));
  sptx_rx_model #(.HALF(4), .NSF(NSF)) u_rx1 (.i_clk(i_clk),
    .i_line(sd[1]), .o_sf(sf1), .o_pre(pre1), .o_count(cnt1), .o_errs(err1));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Format stage output: sample already rotated into bits 23..0, no
  // padding or delay dirty top byte must never be sent
  function automatic logic [31:0] smp(input int n, input int l);
    return {8'hE7, 8'(n), 8'(n * 37 + l * 91), 8'(l)};
  endfunction : smp

  function automatic logic [7:0] faddr(input int i);
    return OFS_FILE + 8'(4 * ((i / 2) * FILE_WORDS + i % 2));
  endfunction : faddr

  // Offer a fresh sample set after every take; one process owns aud
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      take_n <= 0;
      for (int l = 0; l < LN; l++) aud[l] <= smp(0, l);
    end else if (rdy === 1'b1 && i_audio_valid) begin
      take_n <= take_n + 1;
      for (int l = 0; l < LN; l++) aud[l] <= smp(take_n + 1, l);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk);
  endtask : rd

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Run needs about 40k cycles; a hang is cut well after that
  initial begin
    repeat (60000) @(posedge i_clk);
    failures++;
    end_sim();
  end

  initial begin : main
    logic [31:0] d, s0, s1;
    int f, fi;
    {i_wr, i_rd, mclk, bclk, i_addr, i_wdata} = '0;
    i_audio_valid = 1'b1;
    failures = 0;
    compares = 0;
    i_rst_n  = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // Control rows, unmapped address among them, written then read back
    foreach (rows[i]) wr(rows[i].a, rows[i].d);
    foreach (rows[i]) begin
      rd(rows[i].a, d);
      chk("reg row", d, rows[i].e);
    end
    for (int i = 0; i < 8; i++) wr(faddr(i), FW[i]);
    for (int i = 0; i < 8; i++) begin
      rd(faddr(i), d);
      chk("file word", d, FW[i]);
    end
    wr(OFS_CTRL, 32'h0000_0001);
    chk("lane oe", 32'(sd_oe), 32'h0000_0003);
    for (int i = 0; i < NSF * 300 && cnt0 < NSF; i++) @(posedge i_clk);
    chk("idle lane", 32'({sd_oe[2], sd[2]}), 32'h0000_0000);
    // Decoded subframes against sequence, files and samples
    for (int n = 0; n < NSF; n++) begin
      f  = n / 2;
      fi = n % 2;
      s0 = smp(n, 0);
      s1 = smp(n, 1);
      chk("preamble", pre0[n], n == 0 ? PAT_B : fi ? PAT_W : PAT_M);
      chk("preamble1", pre1[n], pre0[n]);
      chk("audio0", sf0[n][27:4], s0[23:0]);
      chk("audio1", sf1[n][27:4], s1[23:0]);
      chk("validity", sf0[n][28], 32'(fi == 0));
      chk("user", sf0[n][29], FW[4 + 2 * fi + f / 32][f % 32]);
      chk("status", sf0[n][30], FW[2 * fi + f / 32][f % 32]);
      chk("parity", 32'(^sf0[n][31:4]), 32'h0000_0000);
      chk("shared bits", sf1[n][30:28], sf0[n][30:28]);
    end
    chk("cell edges", 32'(err0 + err1), 32'h0000_0000);
    // Software finds the word in use from the slot counter
    rd(OFS_STATUS, d);
    chk("slot index", d[8:0], 32'(NSF));
    // Full rate, one half cell per clock, runs past the 384-slot wrap
    wr(OFS_CLK, 32'h0000_0000);
    repeat (20480) @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk("slot wrap", 32'(d[8:0] < 9'(NSF)), 32'h0000_0001);
    // Starve the lanes: underrun flag, clock still healthy
    i_audio_valid <= 1'b0;
    repeat (600) @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk("underrun", d[17:16], 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0002);
    chk("loop idle", loop_en, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0003);
    chk("loop blocked", loop_en, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CLK, 32'h0000_0403);
    chk("mclk out", mco_oe, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0003_0000);
    rd(OFS_STATUS, d);
    chk("flags cleared", d[17:16], 32'h0000_0000);
    // External bit clock: each pin rise is one half-cell tick
    wr(OFS_CLK, 32'h0000_0200);
    wr(OFS_CTRL, 32'h0000_0001);
    s0[0] = bco;
    repeat (3) begin
      bclk <= 1'b1;
      @(posedge i_clk);
      bclk <= 1'b0;
      @(posedge i_clk);
    end
    @(posedge i_clk);
    chk("bit clock out", bco, 32'(!s0[0]));
    s0[0] = mco;
    @(posedge i_clk);
    chk("aux clock", mco, 32'(!s0[0]));
    // External master clock that keeps moving must not be flagged
    wr(OFS_CLK, 32'h0000_0100);
    wr(OFS_STATUS, 32'h0001_0000);
    repeat (4 * CCM) begin
      mclk <= ~mclk;
      @(posedge i_clk);
    end
    rd(OFS_STATUS, d);
    chk("clock alive", d[16], 32'h0000_0000);
    // External master clock that never moves must be flagged
    wr(OFS_CLK, 32'h0000_0503);
    chk("mclk in", mco_oe, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (CCM + 4) @(posedge i_clk);
    rd(OFS_STATUS, d);
    chk("clock fail", d[16], 32'h0000_0001);
    // Second reset in mid-run
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("reset pins", 32'({sd_oe, loop_en, mco_oe}), 32'h0);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(OFS_SLOTEN, d);
    chk("slot en reset", d, SLOTEN_RST);
    rd(OFS_CLK, d);
    chk("clk reset", d, {24'h00_0000, DIV_RST});
    end_sim();
  end
endmodule : tb_top
